// ### design/iprb_level_field.v
// one three-bit priority field with reset to level four
`timescale 1ns/1ps
module iprb_level_field (
  input  wire       clk,
  input  wire       resetn,
  input  wire       wrEn,
  input  wire [2:0] wrData,
  output reg  [2:0] level
);
`include "iprb_map.vh"

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level <= `IPRB_LEVEL_RESET;
    end else if (wrEn) begin
      level <= wrData;
    end
  end

endmodule // iprb_level_field

// ### design/iprb_priority_bank.v
// apb slave holding seven interrupt priority registers
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps

// Operation
// - field 111 means level seven
// - 001 lowest level, 000 disables source
// - unimplemented bits read zero, ignore writes
// - reset sets field top bit only
// - every source starts at level four
// - ext irq one at bits 2..0
// - serial two tx 14..12, rx 10..8
// - ext irq two 6..4, timer five 2..0
// - sync serial event 6..4, fault 2..0
// - capture five, four, three placement
// - compare five at bits 6..4
// - parallel port at bits 6..4
module iprb_priority_bank (
  // clock and asynchronous active-low reset
  input  wire        clk,
  input  wire        resetn,
  // register bus
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // priority levels toward the arbiter
  output wire [2:0]  ext_irq_one_level,
  output wire [2:0]  timer_four_level,
  output wire [2:0]  compare_four_level,
  output wire [2:0]  compare_three_level,
  output wire [2:0]  serial_two_tx_level,
  output wire [2:0]  serial_two_rx_level,
  output wire [2:0]  ext_irq_two_level,
  output wire [2:0]  timer_five_level,
  output wire [2:0]  sync_serial_two_event_level,
  output wire [2:0]  sync_serial_two_fault_level,
  output wire [2:0]  capture_five_level,
  output wire [2:0]  capture_four_level,
  output wire [2:0]  capture_three_level,
  output wire [2:0]  compare_five_level,
  output wire [2:0]  parallel_port_level,
  // source enables toward the arbiter
  output wire        ext_irq_one_enabled,
  output wire        timer_four_enabled,
  output wire        compare_four_enabled,
  output wire        compare_three_enabled,
  output wire        serial_two_tx_enabled,
  output wire        serial_two_rx_enabled,
  output wire        ext_irq_two_enabled,
  output wire        timer_five_enabled,
  output wire        sync_serial_two_event_enabled,
  output wire        sync_serial_two_fault_enabled,
  output wire        capture_five_enabled,
  output wire        capture_four_enabled,
  output wire        capture_three_enabled,
  output wire        compare_five_enabled,
  output wire        parallel_port_enabled
);
`include "iprb_map.vh"

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  localparam NFIELD = 15;

  wire        access   = psel & penable;
  wire        wrAccess = access & pwrite;
  wire        hitExt1  = (paddr == `IPRB_OFS_EXT1);
  wire        hitT4c   = (paddr == `IPRB_OFS_TMR4CMP);
  wire        hitSer2  = (paddr == `IPRB_OFS_SER2);
  wire        hitSpi2  = (paddr == `IPRB_OFS_SPI2);
  wire        hitCap   = (paddr == `IPRB_OFS_CAP345);
  wire        hitCmp5  = (paddr == `IPRB_OFS_CMP5);
  wire        hitPport = (paddr == `IPRB_OFS_PPORT);
  wire        anyHit   = hitExt1 | hitT4c | hitSer2 | hitSpi2 |
                         hitCap | hitCmp5 | hitPport;

  // zero wait states keeps the bank simple; every access ends at once
  assign pready  = 1'b1;
  // unmapped addresses answer with an error and change nothing
  assign pslverr = access & ~anyHit;

  // lane 0 holds bits 7..0, lane 1 bits 15..8 of each register
  wire loLane = pstrb[0];
  wire hiLane = pstrb[1];

  // -------------------------------------------------------------
  // write enables per register and byte lane
  // -------------------------------------------------------------
  // lanes 2 and 3 carry nothing: the upper half of every word is
  // unimplemented, so those strobes are left unread on purpose
  // fifth register: low lane only
  wire wrExt1Lo  = wrAccess & hitExt1 & loLane;
  // sixth register: both lanes
  wire wrT4cHi   = wrAccess & hitT4c & hiLane;
  wire wrT4cLo   = wrAccess & hitT4c & loLane;
  // seventh register: both lanes
  wire wrSer2Hi  = wrAccess & hitSer2 & hiLane;
  wire wrSer2Lo  = wrAccess & hitSer2 & loLane;
  // eighth register: low lane only
  wire wrSpi2Lo  = wrAccess & hitSpi2 & loLane;
  // ninth register: both lanes
  wire wrCapHi   = wrAccess & hitCap & hiLane;
  wire wrCapLo   = wrAccess & hitCap & loLane;
  // tenth register: low lane only
  wire wrCmp5Lo  = wrAccess & hitCmp5 & loLane;
  // eleventh register: low lane only
  wire wrPportLo = wrAccess & hitPport & loLane;

  // -------------------------------------------------------------
  // field storage
  // -------------------------------------------------------------
  wire [NFIELD-1:0] fieldWr;
  wire [NFIELD*3-1:0] fieldIn;
  wire [NFIELD*3-1:0] fieldOut;

  assign fieldWr[0]  = wrExt1Lo;
  assign fieldIn[2:0] = pwdata[`IPRB_POS_LO0 +: 3];
  assign fieldWr[1]  = wrT4cHi;
  assign fieldIn[5:3] = pwdata[`IPRB_POS_HI +: 3];
  assign fieldWr[2]  = wrT4cHi;
  assign fieldIn[8:6] = pwdata[`IPRB_POS_MID +: 3];
  assign fieldWr[3]  = wrT4cLo;
  assign fieldIn[11:9] = pwdata[`IPRB_POS_LO4 +: 3];
  assign fieldWr[4]  = wrSer2Hi;
  assign fieldIn[14:12] = pwdata[`IPRB_POS_HI +: 3];
  assign fieldWr[5]  = wrSer2Hi;
  assign fieldIn[17:15] = pwdata[`IPRB_POS_MID +: 3];
  assign fieldWr[6]  = wrSer2Lo;
  assign fieldIn[20:18] = pwdata[`IPRB_POS_LO4 +: 3];
  assign fieldWr[7]  = wrSer2Lo;
  assign fieldIn[23:21] = pwdata[`IPRB_POS_LO0 +: 3];
  assign fieldWr[8]  = wrSpi2Lo;
  assign fieldIn[26:24] = pwdata[`IPRB_POS_LO4 +: 3];
  assign fieldWr[9]  = wrSpi2Lo;
  assign fieldIn[29:27] = pwdata[`IPRB_POS_LO0 +: 3];
  assign fieldWr[10] = wrCapHi;
  assign fieldIn[32:30] = pwdata[`IPRB_POS_HI +: 3];
  assign fieldWr[11] = wrCapHi;
  assign fieldIn[35:33] = pwdata[`IPRB_POS_MID +: 3];
  assign fieldWr[12] = wrCapLo;
  assign fieldIn[38:36] = pwdata[`IPRB_POS_LO4 +: 3];
  assign fieldWr[13] = wrCmp5Lo;
  assign fieldIn[41:39] = pwdata[`IPRB_POS_LO4 +: 3];
  assign fieldWr[14] = wrPportLo;
  assign fieldIn[44:42] = pwdata[`IPRB_POS_LO4 +: 3];

  genvar g;
  generate
    for (g = 0; g < NFIELD; g = g + 1) begin : gField
      iprb_level_field uField (
        .clk    (clk),
        .resetn (resetn),
        .wrEn   (fieldWr[g]),
        .wrData (fieldIn[g*3 +: 3]),
        .level  (fieldOut[g*3 +: 3])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // arbitration outputs
  // -------------------------------------------------------------
  // continuous level outputs
  // fifth register
  assign ext_irq_one_level           = fieldOut[2:0];

  // sixth register
  assign timer_four_level            = fieldOut[5:3];
  assign compare_four_level          = fieldOut[8:6];
  assign compare_three_level         = fieldOut[11:9];

  // seventh register
  assign serial_two_tx_level         = fieldOut[14:12];
  assign serial_two_rx_level         = fieldOut[17:15];
  assign ext_irq_two_level           = fieldOut[20:18];
  assign timer_five_level            = fieldOut[23:21];

  // eighth register
  assign sync_serial_two_event_level = fieldOut[26:24];
  assign sync_serial_two_fault_level = fieldOut[29:27];

  // ninth register
  assign capture_five_level          = fieldOut[32:30];
  assign capture_four_level          = fieldOut[35:33];
  assign capture_three_level         = fieldOut[38:36];

  // tenth register
  assign compare_five_level          = fieldOut[41:39];

  // eleventh register
  assign parallel_port_level         = fieldOut[44:42];

  // level 111 is the top user level and passes unchanged;
  // any nonzero level from 001 upward may request service
  // seven is highest
  wire [NFIELD-1:0] srcOn;
  generate
    for (g = 0; g < NFIELD; g = g + 1) begin : gOn
      assign srcOn[g] = (fieldOut[g*3 +: 3] != `IPRB_LEVEL_OFF);
    end
  endgenerate

  // fifth register
  assign ext_irq_one_enabled           = srcOn[0];
  // sixth register
  assign timer_four_enabled            = srcOn[1];
  assign compare_four_enabled          = srcOn[2];
  assign compare_three_enabled         = srcOn[3];
  // seventh register
  assign serial_two_tx_enabled         = srcOn[4];
  assign serial_two_rx_enabled         = srcOn[5];
  assign ext_irq_two_enabled           = srcOn[6];
  assign timer_five_enabled            = srcOn[7];
  // eighth register
  assign sync_serial_two_event_enabled = srcOn[8];
  assign sync_serial_two_fault_enabled = srcOn[9];
  // ninth register
  assign capture_five_enabled          = srcOn[10];
  assign capture_four_enabled          = srcOn[11];
  assign capture_three_enabled         = srcOn[12];
  // tenth register
  assign compare_five_enabled          = srcOn[13];
  // eleventh register
  assign parallel_port_enabled         = srcOn[14];

  // -------------------------------------------------------------
  // read data
  // -------------------------------------------------------------
  // unused bits zero
  // each image ties its unimplemented positions to zero, so reads
  // return zero there whatever software wrote earlier
  // fifth register image
  wire [15:0] imgExt1 = {
    13'h0000,                // bits 15..3 unimplemented
    fieldOut[2:0]            // ext irq one
  };

  wire [15:0] imgT4c = {
    1'b0,
    fieldOut[5:3],           // timer four
    1'b0,
    fieldOut[8:6],           // compare four
    1'b0,
    fieldOut[11:9],          // compare three
    4'h0
  };

  wire [15:0] imgSer2 = {
    1'b0,
    fieldOut[14:12],         // serial two tx
    1'b0,
    fieldOut[17:15],         // serial two rx
    1'b0,
    fieldOut[20:18],         // ext irq two
    1'b0,
    fieldOut[23:21]          // timer five
  };

  wire [15:0] imgSpi2 = {
    9'h000,                  // bits 15..7 unimplemented
    fieldOut[26:24],         // sync serial event
    1'b0,
    fieldOut[29:27]          // sync serial fault
  };

  wire [15:0] imgCap = {
    1'b0,
    fieldOut[32:30],         // capture five
    1'b0,
    fieldOut[35:33],         // capture four
    1'b0,
    fieldOut[38:36],         // capture three
    4'h0
  };

  wire [15:0] imgCmp5 = {
    9'h000,                  // bits 15..7 unimplemented
    fieldOut[41:39],         // compare five
    4'h0
  };

  wire [15:0] imgPport = {
    9'h000,                  // bits 15..7 unimplemented
    fieldOut[44:42],         // parallel port
    4'h0
  };

  // -------------------------------------------------------------
  // read data register
  // -------------------------------------------------------------
  // read data is captured in the setup cycle so it already stands
  // when the access phase samples it; a write leaves it untouched
  wire rdSetup = psel & ~penable & ~pwrite;

  reg  [31:0] next_prdata;
  always @* begin
    next_prdata = prdata;
    if (rdSetup) begin
      case (paddr)
        `IPRB_OFS_EXT1:    next_prdata = {16'h0000, imgExt1};
        `IPRB_OFS_TMR4CMP: next_prdata = {16'h0000, imgT4c};
        `IPRB_OFS_SER2:    next_prdata = {16'h0000, imgSer2};
        `IPRB_OFS_SPI2:    next_prdata = {16'h0000, imgSpi2};
        `IPRB_OFS_CAP345:  next_prdata = {16'h0000, imgCap};
        `IPRB_OFS_CMP5:    next_prdata = {16'h0000, imgCmp5};
        `IPRB_OFS_PPORT:   next_prdata = {16'h0000, imgPport};
        // unmapped words read as zero
        default:           next_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule // iprb_priority_bank

// ### include/iprb_map.vh
// register offsets, field positions and reset values of the priority bank
`ifndef IPRB_MAP_VH
`define IPRB_MAP_VH

// byte offsets on the register bus
`define IPRB_OFS_EXT1        12'h000
`define IPRB_OFS_TMR4CMP     12'h004
`define IPRB_OFS_SER2        12'h008
`define IPRB_OFS_SPI2        12'h00C
`define IPRB_OFS_CAP345      12'h010
`define IPRB_OFS_CMP5        12'h014
`define IPRB_OFS_PPORT       12'h018

// field low-bit positions; each field is three bits wide
`define IPRB_POS_HI          12
`define IPRB_POS_MID         8
`define IPRB_POS_LO4         4
`define IPRB_POS_LO0         0

// level four at reset: top bit set, lower two clear
`define IPRB_LEVEL_RESET     3'h4
`define IPRB_LEVEL_OFF       3'h0
`define IPRB_LEVEL_TOP       3'h7
`define IPRB_LEVEL_LOW       3'h1

`endif

// ### sim/iprb_priority_bank_props.sv
// concurrent checks on the priority register bank ports
`timescale 1ns/1ps
module iprb_check (
  input logic        clk,
  input logic        resetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic        pready,
  input logic [31:0] prdata,
  input logic [2:0]  ext_irq_one_level,
  input logic [2:0]  timer_four_level,
  input logic [2:0]  serial_two_tx_level,
  input logic [2:0]  ext_irq_two_level,
  input logic [2:0]  timer_five_level,
  input logic [2:0]  sync_serial_two_fault_level,
  input logic [2:0]  capture_five_level,
  input logic [2:0]  compare_five_level,
  input logic [2:0]  parallel_port_level,
  input logic        ext_irq_one_enabled
);
  // ----------------------------------------
  // write strobe as the slave sees it
  // ----------------------------------------
  wire wr = psel & penable & pwrite & pready;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  reset_level_a: assert property (
    $rose(resetn) |-> ext_irq_one_level == 3'h4 && parallel_port_level == 3'h4)
    else $error("field not at level four after reset");
  ext1_store_a: assert property (
    wr && paddr == 12'h000 && pstrb[0] |=> ext_irq_one_level == $past(pwdata[2:0]))
    else $error("ext irq one field not stored");
  tmr4_store_a: assert property (
    wr && paddr == 12'h004 && pstrb[1] |=> timer_four_level == $past(pwdata[14:12]))
    else $error("timer four field not stored");
  serial_tx_store_a: assert property (
    wr && paddr == 12'h008 && pstrb[1] |=> serial_two_tx_level == $past(pwdata[14:12]))
    else $error("serial tx field not stored");
  int2_tmr5_a: assert property (
    wr && paddr == 12'h008 && pstrb[0] |=> ext_irq_two_level == $past(pwdata[6:4])
    && timer_five_level == $past(pwdata[2:0])) else $error("irq two or timer five wrong");
  spi_fault_a: assert property (
    wr && paddr == 12'h00C && pstrb[0] |=> sync_serial_two_fault_level == $past(pwdata[2:0]))
    else $error("sync serial fault field not stored");
  cap5_store_a: assert property (
    wr && paddr == 12'h010 && pstrb[1] |=> capture_five_level == $past(pwdata[14:12]))
    else $error("capture five field not stored");
  cmp5_store_a: assert property (
    wr && paddr == 12'h014 && pstrb[0] |=> compare_five_level == $past(pwdata[6:4]))
    else $error("compare five field not stored");
  pport_store_a: assert property (
    wr && paddr == 12'h018 && pstrb[0] |=> parallel_port_level == $past(pwdata[6:4]))
    else $error("parallel port field not stored");
  level_hold_a: assert property (
    !wr |=> $stable(parallel_port_level)) else $error("field moved without a write");
  off_enable_a: assert property (
    ext_irq_one_enabled == (ext_irq_one_level != 3'h0)) else $error("enable flag wrong");
  upper_zero_a: assert property (
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  cover property (wr && paddr == 12'h01C);
  cover property (wr && paddr == 12'h018 && pwdata[6:4] == 3'h7);
  cover property ($rose(resetn));
endmodule // iprb_check

bind iprb_priority_bank iprb_check u_check (.clk, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .ext_irq_one_level,
  .timer_four_level, .serial_two_tx_level, .ext_irq_two_level,
  .timer_five_level, .sync_serial_two_fault_level, .capture_five_level,
  .compare_five_level, .parallel_port_level, .ext_irq_one_enabled);

// ### sim/iprb_testbench.sv
// self-checking bench for the priority register bank
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdWord;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, err, en1;
  logic [2:0]  lvl1, lvlPp;
  logic [15:0] msk [7] = '{16'h0007, 16'h7770, 16'h7777, 16'h0077,
                           16'h7770, 16'h0070, 16'h0070};
  logic [31:0] pats [3] = '{32'hFFFFFFFF, 32'h11111111, 32'h00000000};
  int          err_total = 0, n_compared = 0;
  iprb_priority_bank DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .prdata, .ext_irq_one_level(lvl1),
    .parallel_port_level(lvlPp), .ext_irq_one_enabled(en1),
    .timer_four_level(), .compare_four_level(), .compare_three_level(),
    .serial_two_tx_level(), .serial_two_rx_level(), .ext_irq_two_level(),
    .timer_five_level(), .sync_serial_two_event_level(),
    .sync_serial_two_fault_level(), .capture_five_level(),
    .capture_four_level(), .capture_three_level(), .compare_five_level(),
    .timer_four_enabled(), .compare_four_enabled(),
    .compare_three_enabled(), .serial_two_tx_enabled(),
    .serial_two_rx_enabled(), .ext_irq_two_enabled(), .timer_five_enabled(),
    .sync_serial_two_event_enabled(), .sync_serial_two_fault_enabled(),
    .capture_five_enabled(), .capture_four_enabled(),
    .capture_three_enabled(), .compare_five_enabled(),
    .parallel_port_enabled());
  initial forever #5 clk = ~clk;
  // ----------------------------------------
  // bus access and comparison
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdWord = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic defaults;
    for (int i = 0; i < 7; i++) begin
      xfer(0, 12'(i * 4), 0, 0);
      chk("reset value", rdWord, msk[i] & 16'h4444);
    end
    chk("start level", lvl1, 3'h4);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    defaults();
    // top, lowest and off levels in every field
    for (int v = 0; v < 3; v++) begin
      for (int i = 0; i < 7; i++) begin
        xfer(1, 12'(i * 4), pats[v], 4'hF);
        xfer(0, 12'(i * 4), 0, 0);
        chk("field readback", rdWord, pats[v] & msk[i]);
      end
      chk("ext irq one", lvl1, pats[v][2:0]);
      chk("enabled", en1, pats[v][2:0] != 3'h0);
      chk("parallel port", lvlPp, pats[v][6:4]);
    end
    // lane one only: lower fields keep their old value
    xfer(1, 12'h008, 32'h7777, 4'h1);
    xfer(1, 12'h008, 32'h5533, 4'h2);
    xfer(0, 12'h008, 0, 0);
    chk("lane write", rdWord, 32'h5577);
    xfer(1, 12'h01C, 32'hFFFFFFFF, 4'hF);
    chk("unmapped write", err, 1'b1);
    xfer(0, 12'h01C, 0, 0);
    chk("unmapped read", rdWord, 32'h0);
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    defaults();
    complete_run();
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // testbench
